/* logic/pcsk_irq_route.sv */
// Interrupt steering for card functional and status-change interrupts
`timescale 1ns/1ps
`include "pcsk_params.svh"

module pcsk_irq_route #(
   parameter int NUM_LINES = 16
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset,
   // Interrupt sources
   input  wire logic                 func_irq,
   input  wire logic                 csc_irq,
   input  wire logic                 io_card,
   // Routing controls
   input  wire logic [3:0]           functional_irq_line_select,
   input  wire logic                 status_change_host_routing,
   input  wire logic [3:0]           status_change_line_select,
   // Routed outputs
   output logic      [NUM_LINES-1:0] irq_lines,
   output logic                      system_management_interrupt,
   output logic                      host_int
);
   import pcsk_pkg::*;

   // Only a full set of sixteen legacy lines can be served
   if (NUM_LINES != 16) begin : g_bad_lines
      $error("pcsk_irq_route: NUM_LINES must be 16");
   end

   // One-hot legacy line for a select code, none for zero or the system management code
   function automatic logic [NUM_LINES-1:0] line_of(input logic [3:0] code);
      logic [NUM_LINES-1:0] v;
      v = '0;
      if (code != `PCSK_SEL_NONE && code != `PCSK_SEL_SYS_MGMT) begin
         v[code] = 1'b1;
      end
      return v;
   endfunction : line_of

   logic                 func_act;
   logic                 func_host;
   logic [NUM_LINES-1:0] lines_d;
   logic                 smi_d;
   logic                 host_d;

   // Functional interrupts come only from I/O cards
   always_comb begin
      func_act  = func_irq & io_card;
      func_host = (functional_irq_line_select == `PCSK_SEL_NONE)
                  | status_change_host_routing;
      lines_d   = '0;
      smi_d     = 1'b0;
      host_d    = 1'b0;
      if (func_act) begin
         if (func_host) begin
            host_d = 1'b1;
         end else if (functional_irq_line_select == `PCSK_SEL_SYS_MGMT) begin
            smi_d = 1'b1;
         end else begin
            lines_d = line_of(functional_irq_line_select);
         end
      end
      if (csc_irq) begin
         if (status_change_host_routing) begin
            host_d = 1'b1;
         end else if (status_change_line_select == `PCSK_SEL_SYS_MGMT) begin
            smi_d = 1'b1;
         end else begin
            lines_d = lines_d | line_of(status_change_line_select);
         end
      end
   end

   // Registered routed outputs
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_lines                   <= '0;
         system_management_interrupt <= 1'b0;
         host_int                    <= 1'b0;
      end else begin
         irq_lines                   <= lines_d;
         system_management_interrupt <= smi_d;
         host_int                    <= host_d;
      end
   end

endmodule : pcsk_irq_route

/* logic/pcsk_params.svh */
// Offsets, field positions, reset values and codes of the socket control block
`ifndef PCSK_PARAMS_SVH
`define PCSK_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets in the socket register space
// ----------------------------------------------------------------
`define PCSK_OFS_POWER      8'h02
`define PCSK_OFS_IRQGEN     8'h03

// ----------------------------------------------------------------
// Power control fields
// ----------------------------------------------------------------
`define PCSK_PWR_GATE       7
`define PCSK_PWR_AUTO       5
`define PCSK_PWR_SUPPLY_EN  4
`define PCSK_PWR_VCC_HI     4
`define PCSK_PWR_VCC_LO     3
`define PCSK_PWR_VPP_HI     1
`define PCSK_PWR_VPP_LO     0
`define PCSK_PWR_MASK_L1    8'hB3
`define PCSK_PWR_MASK_L2    8'h9B
`define PCSK_PWR_RESET      8'h00

// ----------------------------------------------------------------
// Interrupt and general control fields
// ----------------------------------------------------------------
`define PCSK_IG_RING        7
`define PCSK_IG_CARD_RUN    6
`define PCSK_IG_IO_CARD     5
`define PCSK_IG_CSC_ROUTE   4
`define PCSK_IG_SEL_HI      3
`define PCSK_IG_SEL_LO      0
`define PCSK_IG_RESET       8'h00

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define PCSK_COMPAT_CODE    4'h2
`define PCSK_SEL_NONE       4'h0
`define PCSK_SEL_SYS_MGMT   4'h2
`define PCSK_VCC_5V         2'h2
`define PCSK_VCC_3V3        2'h3

`endif

/* logic/pcsk_pkg.sv */
// Types shared by the socket control block
package pcsk_pkg;

   // Card Vpp request codes
   typedef enum logic [1:0] {
      PCSK_VPP_NONE = 2'b00,
      PCSK_VPP_VCC  = 2'b01,
      PCSK_VPP_12V  = 2'b10,
      PCSK_VPP_RSVD = 2'b11
   } pcsk_vpp_t;

   // Power control bit layout
   typedef enum logic [0:0] {
      PCSK_LAYOUT_COMPAT = 1'b0,
      PCSK_LAYOUT_EXT    = 1'b1
   } pcsk_layout_t;

endpackage : pcsk_pkg

/* logic/pcsk_socket_ctrl.sv */
// Socket power and interrupt/general control registers for a 16-bit card socket
`timescale 1ns/1ps
`include "pcsk_params.svh"

module pcsk_socket_ctrl (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                reset,
   // Socket register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [7:0]          reg_wdata,
   output logic      [7:0]          reg_rdata,
   // Settings held elsewhere in the controller
   input  wire logic [3:0]          legacy_revision_field,
   input  wire logic                system_supply_control_bit,
   input  wire logic [3:0]          status_change_line_select,
   // Card side
   input  wire logic                card_present,
   input  wire logic                card_func_irq,
   input  wire logic                csc_irq,
   output logic                     card_output_gate,
   output logic                     card_reset,
   output logic                     ring_indicate_enable,
   output logic                     card_supply_enable,
   output logic      [1:0]          supply_voltage_out,
   output pcsk_pkg::pcsk_vpp_t      program_voltage_out,
   output logic                     socket_power_status,
   // Interrupt routing
   output logic      [15:0]         irq_lines,
   output logic                     system_management_interrupt,
   output logic                     host_int
);
   import pcsk_pkg::*;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0]   pwr_q;
   logic [7:0]   irq_gen_q;
   pcsk_layout_t layout;
   logic [7:0]   pwr_mask;
   logic         wr_pwr;
   logic         wr_ig;
   logic         rd_pwr;
   logic         rd_ig;

   // Address decode
   always_comb begin
      wr_pwr = 1'b0;
      wr_ig  = 1'b0;
      rd_pwr = 1'b0;
      rd_ig  = 1'b0;
      if (reg_addr == `PCSK_OFS_POWER) begin
         wr_pwr = reg_wr;
         rd_pwr = reg_rd;
      end else if (reg_addr == `PCSK_OFS_IRQGEN) begin
         wr_ig = reg_wr;
         rd_ig = reg_rd;
      end
   end

   // Layout choice follows the revision field
   always_comb begin
      if (legacy_revision_field == `PCSK_COMPAT_CODE) begin
         layout   = PCSK_LAYOUT_COMPAT;
         pwr_mask = `PCSK_PWR_MASK_L1;
      end else begin
         layout   = PCSK_LAYOUT_EXT;
         pwr_mask = `PCSK_PWR_MASK_L2;
      end
   end

   // Power control register; only bits live in the current layout take a write
   always_ff @(posedge mclk) begin
      if (reset) begin
         pwr_q <= `PCSK_PWR_RESET;
      end else if (wr_pwr) begin
         pwr_q <= (reg_wdata & pwr_mask) | (pwr_q & ~pwr_mask);
      end
   end

   // Interrupt and general control register, all bits read/write
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_gen_q <= `PCSK_IG_RESET;
      end else if (wr_ig) begin
         irq_gen_q <= reg_wdata;
      end
   end

   // Read data, registered; unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (rd_pwr) begin
         reg_rdata <= pwr_q & pwr_mask;
      end else if (rd_ig) begin
         reg_rdata <= irq_gen_q;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Socket power
   // ----------------------------------------------------------------
   logic       vcc_on;
   logic [1:0] vcc_code;
   logic [1:0] vcc_req;

   // Vcc decision per layout
   always_comb begin
      vcc_req = pwr_q[`PCSK_PWR_VCC_HI:`PCSK_PWR_VCC_LO];
      if (layout == PCSK_LAYOUT_COMPAT) begin
         vcc_on = pwr_q[`PCSK_PWR_SUPPLY_EN] & system_supply_control_bit;
         if (pwr_q[`PCSK_PWR_AUTO] && !card_present) begin
            vcc_on = 1'b0;
         end
         vcc_code = vcc_on ? `PCSK_VCC_5V : 2'h0;
      end else begin
         vcc_on   = (vcc_req == `PCSK_VCC_5V) || (vcc_req == `PCSK_VCC_3V3);
         vcc_code = vcc_on ? vcc_req : 2'h0;
      end
   end

   // Registered socket power outputs
   always_ff @(posedge mclk) begin
      if (reset) begin
         card_supply_enable  <= 1'b0;
         supply_voltage_out  <= 2'h0;
         program_voltage_out <= PCSK_VPP_NONE;
         socket_power_status <= 1'b0;
      end else begin
         card_supply_enable  <= vcc_on;
         supply_voltage_out  <= vcc_code;
         program_voltage_out <= vcc_on ?
            pcsk_vpp_t'(pwr_q[`PCSK_PWR_VPP_HI:`PCSK_PWR_VPP_LO]) :
            PCSK_VPP_NONE;
         socket_power_status <= vcc_on;
      end
   end

   // ----------------------------------------------------------------
   // Card control
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         card_output_gate     <= 1'b0;
         card_reset           <= 1'b1;
         ring_indicate_enable <= 1'b0;
      end else begin
         card_output_gate     <= pwr_q[`PCSK_PWR_GATE];
         card_reset           <= ~irq_gen_q[`PCSK_IG_CARD_RUN];
         ring_indicate_enable <= irq_gen_q[`PCSK_IG_RING];
      end
   end

   // Interrupt steering; card type gates functional interrupts
   pcsk_irq_route #(
      .NUM_LINES (16)
   ) u_route (
      .mclk                        (mclk),
      .reset                       (reset),
      .func_irq                    (card_func_irq),
      .csc_irq                     (csc_irq),
      .io_card                     (irq_gen_q[`PCSK_IG_IO_CARD]),
      .functional_irq_line_select  (irq_gen_q[`PCSK_IG_SEL_HI:`PCSK_IG_SEL_LO]),
      .status_change_host_routing  (irq_gen_q[`PCSK_IG_CSC_ROUTE]),
      .status_change_line_select   (status_change_line_select),
      .irq_lines                   (irq_lines),
      .system_management_interrupt (system_management_interrupt),
      .host_int                    (host_int)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_gate_write: assert property (
      wr_pwr |-> ##2 card_output_gate == $past(reg_wdata[7], 2))
      else $error("card output gate does not follow power bit 7");

   a_l1_rsvd_zero: assert property (
      rd_pwr && layout == PCSK_LAYOUT_COMPAT |=> reg_rdata[6] == 1'b0
         && reg_rdata[3:2] == 2'b00)
      else $error("first layout reserved power bits read nonzero");

   a_l2_rsvd_zero: assert property (
      rd_pwr && layout == PCSK_LAYOUT_EXT |=> reg_rdata[6:5] == 2'b00
         && reg_rdata[2] == 1'b0)
      else $error("second layout reserved power bits read nonzero");

   a_auto_switch_off: assert property (
      layout == PCSK_LAYOUT_COMPAT && pwr_q[5] && !card_present
         |=> !card_supply_enable)
      else $error("Vcc on with auto switching and no card");

   a_vpp_gated: assert property (
      !socket_power_status |-> program_voltage_out == PCSK_VPP_NONE)
      else $error("Vpp applied while Vcc is off");

   a_vcc_code: assert property (
      layout == PCSK_LAYOUT_EXT && pwr_q[4:3] == 2'b01 |=> !socket_power_status)
      else $error("reserved Vcc code turned Vcc on");

   a_status_power: assert property (
      socket_power_status == card_supply_enable
         && (socket_power_status == (supply_voltage_out != 2'h0)))
      else $error("power status disagrees with supply outputs");

   a_card_reset: assert property (
      wr_ig |-> ##2 card_reset == !$past(reg_wdata[6], 2))
      else $error("card reset does not follow control bit 6");

   a_ring_enable: assert property (
      wr_ig |-> ##2 ring_indicate_enable == $past(reg_wdata[7], 2))
      else $error("ring indicate enable wrong");

   a_ig_readback: assert property (
      wr_ig ##1 (rd_ig && !wr_ig) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("control register readback mismatch");

   a_reset_zero: assert property (
      $fell(reset) |-> pwr_q == 8'h00 && irq_gen_q == 8'h00 && !card_output_gate)
      else $error("registers not zero after reset");

endmodule : pcsk_socket_ctrl

/* test/pcsk_card_model.sv */
// Behavioural 16-bit card sitting in the socket
`timescale 1ns/1ps

module pcsk_card_model (
   // Clock
   input  wire logic mclk,
   // Socket side
   input  wire logic card_reset,
   input  wire logic card_supply_enable,
   output logic      card_present,
   output logic      card_func_irq,
   // Bench controls
   input  wire logic insert,
   input  wire logic irq_req
);
   // Both card detects follow insertion
   assign card_present = insert;

   // An unpowered or held card never signals, so the line stays low then
   always_ff @(posedge mclk) begin
      card_func_irq <= irq_req & card_supply_enable & ~card_reset;
   end
endmodule : pcsk_card_model

/* test/testbench.sv */
// Self-checking bench for the socket power and interrupt/general control registers
`timescale 1ns/1ps
`include "pcsk_params.svh"

module testbench;
   import pcsk_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        mclk, reset, reg_wr, reg_rd, system_supply_control_bit;
   logic        card_present, card_func_irq, csc_irq, insert, irq_req;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, a, d;
   logic [3:0]  legacy_revision_field, status_change_line_select;
   logic        card_output_gate, card_reset, ring_indicate_enable, card_supply_enable;
   logic [1:0]  supply_voltage_out;
   pcsk_vpp_t   program_voltage_out;
   logic        socket_power_status, system_management_interrupt, host_int, w, r;
   logic [15:0] irq_lines;
   int          bad_count, check_count, seed, pwr, ig, i;

   pcsk_socket_ctrl dut (.mclk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .legacy_revision_field, .system_supply_control_bit,
      .status_change_line_select, .card_present, .card_func_irq, .csc_irq,
      .card_output_gate, .card_reset, .ring_indicate_enable, .card_supply_enable,
      .supply_voltage_out, .program_voltage_out, .socket_power_status, .irq_lines,
      .system_management_interrupt, .host_int);

   pcsk_card_model card (.mclk, .card_reset, .card_supply_enable, .card_present,
      .card_func_irq, .insert, .irq_req);

   // Clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Read value held by the model, masked by the current layout
   function automatic logic [7:0] rexp(input logic [7:0] ad);
      if (ad == `PCSK_OFS_POWER)
         return pwr[7:0] & ((legacy_revision_field == 4'h2) ? 8'hB3 : 8'h9B);
      if (ad == `PCSK_OFS_IRQGEN) return ig[7:0];
      return 8'h00;
   endfunction : rexp

   // One register port cycle, driven at the falling edge
   task automatic bus(input logic wi, input logic ri, input logic [7:0] ad,
                      input logic [7:0] di);
      logic [7:0] e, m;
      e = rexp(ad);
      m = (legacy_revision_field == 4'h2) ? 8'hB3 : 8'h9B;
      reg_wr = wi;
      reg_rd = ri;
      reg_addr = ad;
      reg_wdata = di;
      @(negedge mclk);
      if (reset) begin
         pwr = 0;
         ig = 0;
      end else if (wi && ad == `PCSK_OFS_POWER) pwr = (di & m) | (pwr & ~m);
      else if (wi && ad == `PCSK_OFS_IRQGEN) ig = di;
      chk(reg_rdata, ri ? e : 8'h00, "read data");
   endtask : bus

   // Let the outputs settle, then compare them with the model
   task automatic outs();
      logic on, cmp, fn, es, eh;
      logic [15:0] el;
      repeat (6) bus(1'b0, 1'b0, 8'h00, 8'h00);
      cmp = (legacy_revision_field == 4'h2);
      on = cmp ? pwr[4] & system_supply_control_bit & (!pwr[5] | insert) : pwr[4];
      fn = irq_req & on & ig[6];
      el = 16'h0000;
      es = 1'b0;
      eh = 1'b0;
      if (ig[5] && fn) begin
         if (ig[3:0] == 0 || ig[4]) eh = 1'b1;
         else if (ig[3:0] == 2) es = 1'b1;
         else el[ig[3:0]] = 1'b1;
      end
      if (csc_irq) begin
         if (ig[4]) eh = 1'b1;
         else if (status_change_line_select == 2) es = 1'b1;
         else if (status_change_line_select != 0) el[status_change_line_select] = 1'b1;
      end
      chk(card_output_gate, pwr[7], "output gate");
      chk(card_reset, !ig[6], "card reset");
      chk(ring_indicate_enable, ig[7], "ring enable");
      chk(card_supply_enable, on, "supply enable");
      chk(supply_voltage_out, on ? (cmp ? 2'h2 : pwr[4:3]) : 2'h0, "vcc code");
      chk(program_voltage_out, on ? pwr[1:0] : 2'h0, "vpp code");
      chk(socket_power_status, on, "power status");
      chk(irq_lines, el, "irq lines");
      chk(system_management_interrupt, es, "sys mgmt irq");
      chk(host_int, eh, "host int");
   endtask : outs

   task automatic results();
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   // Watchdog
   initial begin
      repeat (30000) @(posedge mclk);
      bad_count++;
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 54871;
      bad_count = 0;
      check_count = 0;
      pwr = 0;
      ig = 0;
      reset = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
      {system_supply_control_bit, csc_irq, insert, irq_req} = 4'h0;
      legacy_revision_field = 4'h2;
      status_change_line_select = 4'h0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      outs();
      // Every select code, both layouts, functional source always active, status change source on odd passes only
      for (i = 0; i < 32; i++) begin
         legacy_revision_field = i[4] ? 4'h2 : 4'h7;
         {system_supply_control_bit, insert, irq_req} = 3'h7;
         csc_irq = i[0];
         status_change_line_select = ~i[3:0];
         bus(1'b1, 1'b0, 8'h02, {4'h9, i[0], 1'b0, i[2:1]});
         bus(1'b1, 1'b1, 8'h03, {3'h3, i[4], i[3:0]});
         bus(1'b0, 1'b1, 8'h02, 8'h00);
         outs();
      end
      // Random traffic, back to back, unmapped places and layout swaps
      for (i = 0; i < 400; i++) begin
         a = (($random(seed) & 3) == 0) ? 8'($random(seed)) : 8'(2 + ($random(seed) & 1));
         d = 8'($random(seed));
         w = 1'($random(seed));
         r = 1'($random(seed));
         legacy_revision_field = ($random(seed) & 1) ? 4'h2 : 4'($random(seed));
         {system_supply_control_bit, insert, irq_req, csc_irq} = 4'($random(seed));
         status_change_line_select = 4'($random(seed));
         bus(w, r, a, d);
         if (i == 200) begin
            reset = 1'b1;
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            chk(card_reset, 1'b1, "reset held");
            reset = 1'b0;
            outs();
         end
         if (i % 4 == 0) outs();
      end
      results();
   end
endmodule : testbench
